// File: tb/vic_controller_tb.sv
// Self-checking testbench of the vectored interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module vic_controller_tb;
  import vic_pkg::*;

  logic clk, rst, ce, autoAck;
  logic [3:0] ackDelay;
  vic_bus_s bus;
  logic [DATA_W-1:0] rdData;
  logic [NUM_IRQ-1:0] irqLines;
  logic [NUM_TRAP-1:0] trapIn;
  vic_core_s core;
  vic_req_s coreReq, taken;
  logic [LVL_W-1:0] cpuLevel;
  logic [7:0] takenCnt;
  logic [6:0] handlerSlot;
  logic unusedHit;
  int errorCnt, nCompared;

  vic_controller i_vic_controller (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdData(rdData),
    .irqLines(irqLines), .trapIn(trapIn), .core(core), .coreReq(coreReq), .cpuLevel(cpuLevel));
  vic_core_model i_vic_core_model (.clk(clk), .rst(rst), .autoAck(autoAck), .ackDelay(ackDelay),
    .coreReq(coreReq), .cpuLevel(cpuLevel), .core(core), .taken(taken), .takenCnt(takenCnt),
    .handlerSlot(handlerSlot), .unusedHit(unusedHit));

  // ----------------------------------------------------------------
  // Clock, comparison and bus tasks.
  // ----------------------------------------------------------------
  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk) bus <= {a, d, 1'h1, 1'h0};
    @(posedge clk) bus.wr <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk) bus <= {a, 16'h0000, 1'h0, 1'h1};
    @(posedge clk) bus.rd <= 1'h0;
    #1 chk("rdData", rdData, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_req(input logic v);
    int i;
    i = 0;
    while (coreReq.req !== v && i < 50) begin
      settle(1);
      i++;
    end
  endtask

  task automatic wait_taken(input logic [7:0] n);
    int i;
    i = 0;
    while (takenCnt !== n && i < 50) begin
      settle(1);
      i++;
    end
    chk("takenCnt", takenCnt, n);
  endtask

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", errorCnt, nCompared);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errorCnt++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    ce = 1'h1;
    autoAck = 1'h0;
    ackDelay = 4'h3;
    bus = '0;
    irqLines = '0;
    trapIn = '0;
    errorCnt = 0;
    nCompared = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    rd(OFS_CONTROL, 16'h0000);
    rd(OFS_PENDING, 16'h0000);
    rd(8'hff, 16'h0000);
    chk("req", coreReq.req, 1'h0);
    wr(OFS_ENABLE_BASE, 16'h0013);
    wr(OFS_PRIO_BASE, 16'h0001);
    @(posedge clk) irqLines[0] <= 1'h1;
    settle(3);
    chk("reqEarly", coreReq.req, 1'h0);
    settle(1);
    chk("req", coreReq.req, 1'h1);
    chk("num", coreReq.num, 7'h08);
    chk("addr", coreReq.addr, 24'h000014);
    chk("level", coreReq.level, 4'h1);
    @(posedge clk) irqLines[0] <= 1'h0;
    settle(4);
    chk("sticky", coreReq.req, 1'h1);
    rd(OFS_FLAG_BASE, 16'h0001);
    wr(OFS_CONTROL, 16'h8000);
    settle(2);
    chk("altAddr", coreReq.addr, 24'h000114);
    wr(OFS_CONTROL, 16'h0000);
    settle(2);
    chk("priAddr", coreReq.addr, 24'h000014);
    @(posedge clk) autoAck <= 1'h1;
    wait_taken(8'h01);
    chk("takenNum", taken.num, 7'h08);
    chk("slot", handlerSlot, 7'h08);
    chk("unused", unusedHit, 1'h0);
    settle(1);
    chk("cpuLevel", cpuLevel, 4'h1);
    @(posedge clk) autoAck <= 1'h0;
    rd(OFS_PENDING, 16'h0108);
    wr(OFS_FLAG_BASE, 16'h0000);
    settle(60);
    chk("retLevel", cpuLevel, 4'h0);
    chk("reqDone", coreReq.req, 1'h0);
    wr(OFS_PRIO_BASE, 16'h0030);
    wr(OFS_PRIO_BASE + 8'h01, 16'h0003);
    @(posedge clk) irqLines <= (118'h1 << 1) | (118'h1 << 4);
    wait_req(1'h1);
    settle(2);
    chk("tieNum", coreReq.num, 7'h09);
    wr(OFS_PRIO_BASE + 8'h01, 16'h0005);
    settle(2);
    chk("lvlNum", coreReq.num, 7'h0c);
    chk("dmaAddr", coreReq.addr, 24'h00001c);
    wr(OFS_CPU_LEVEL, 16'h0005);
    settle(2);
    chk("masked", coreReq.req, 1'h0);
    wr(OFS_CPU_LEVEL, 16'h000f);
    rd(OFS_CPU_LEVEL, 16'h0007);
    @(posedge clk) trapIn <= 8'h05;
    @(posedge clk) trapIn <= 8'h00;
    wait_req(1'h1);
    chk("trapNum", coreReq.num, 7'h02);
    chk("trapAddr", coreReq.addr, 24'h000008);
    chk("trapLvl", coreReq.level, TRAP_LEVEL);
    rd(OFS_TRAP_FLAGS, 16'h0004);
    wr(OFS_CPU_LEVEL, 16'h0000);
    settle(2);
    chk("trapWins", coreReq.num, 7'h02);
    wr(OFS_TRAP_FLAGS, 16'h0000);
    wr(OFS_ENABLE_BASE, 16'h8013);
    @(posedge clk) irqLines[15] <= 1'h1;
    settle(4);
    rd(OFS_FLAG_BASE, 16'h0012);
    settle(2);
    chk("natural", coreReq.num, 7'h0c);
    wr(OFS_CONTROL, 16'h8000);
    settle(2);
    ackDelay <= 4'h0;
    autoAck <= 1'h1;
    wait_taken(8'h02);
    chk("fastNum", taken.num, 7'h0c);
    chk("altTaken", taken.addr, 24'h00011c);
    chk("altSlot", handlerSlot, 7'h0c);
    chk("altUnused", unusedHit, 1'h0);
    settle(1);
    @(posedge clk) ce <= 1'h0;
    wr(OFS_CONTROL, 16'h0000);
    ce <= 1'h1;
    rd(OFS_CONTROL, 16'h8000);
    final_report();
  end
endmodule // vic_controller_tb
`default_nettype wire

// File: tb/vic_core_model.sv
// Behavioural core that takes controller requests and returns from handlers.
`timescale 1ns/10ps
`default_nettype none
module vic_core_model #(
  parameter int HOLD = 40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic autoAck,
  input wire logic [3:0] ackDelay,
  input wire vic_pkg::vic_req_s coreReq,
  input wire logic [vic_pkg::LVL_W-1:0] cpuLevel,
  output var vic_pkg::vic_core_s core,
  output var vic_pkg::vic_req_s taken,
  output logic [7:0] takenCnt,
  output logic [6:0] handlerSlot,
  output logic unusedHit
);
  import vic_pkg::*;

  logic [3:0] waitCnt;
  logic [7:0] holdCnt;
  logic busy;
  logic [LVL_W-1:0] savedLevel;

  // ----------------------------------------------------------------
  // Take a request after a delay, run the handler, then return.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    core.ack <= 1'h0;
    core.ret <= 1'h0;
    if (rst) begin
      core <= '0;
      taken <= '0;
      takenCnt <= 8'h00;
      handlerSlot <= 7'h00;
      unusedHit <= 1'h0;
      waitCnt <= 4'h0;
      holdCnt <= 8'h00;
      busy <= 1'h0;
      savedLevel <= '0;
    end else if (busy) begin
      holdCnt <= holdCnt + 8'h01;
      if (holdCnt == 8'(HOLD)) begin
        core.ret <= 1'h1;
        core.retLevel <= savedLevel;
        busy <= 1'h0;
      end
    end else if (autoAck && coreReq.req && !core.ack) begin
      if (waitCnt == ackDelay) begin
        core.ack <= 1'h1;
        taken <= coreReq;
        handlerSlot <= coreReq.addr[7:1] - 7'h02;
        unusedHit <= coreReq.num < 7'h08 ? !TRAP_IMPL[coreReq.num[2:0]] :
          IRQ_RESERVED[coreReq.num - 7'h08];
        takenCnt <= takenCnt + 8'h01;
        savedLevel <= cpuLevel;
        busy <= 1'h1;
        holdCnt <= 8'h00;
        waitCnt <= 4'h0;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end else begin
      waitCnt <= 4'h0;
    end
  end
endmodule // vic_core_model
`default_nettype wire

// File: verilog/vic_arbiter.sv
// Fixed-order priority arbiter: highest level wins, lowest index breaks ties.
`timescale 1ns/10ps
`default_nettype none
module vic_arbiter #(
  parameter int N = 8
) (
  input wire logic [N-1:0] eligible,
  input wire logic [N-1:0][vic_pkg::PRIO_W-1:0] prio,
  output logic valid,
  output logic [vic_pkg::VEC_W-1:0] idx,
  output logic [vic_pkg::PRIO_W-1:0] level
);
  import vic_pkg::*;

  if (N < 1 || N + NUM_TRAP > 2 ** VEC_W) begin : g_bad_n
    $error("Source count does not fit the vector number field.");
  end

  always_comb begin
    valid = 1'b0;
    idx = '0;
    level = '0;
    for (int i = 0; i < N; i++) begin
      if (eligible[i] && (!valid || prio[i] > level)) begin
        valid = 1'b1;
        idx = VEC_W'(i);
        level = prio[i];
      end
    end
  end
endmodule // vic_arbiter
`default_nettype wire

// File: verilog/vic_controller.sv
// Vectored interrupt controller with register port and core request.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module vic_controller #(
  parameter int IRQ_COUNT = vic_pkg::NUM_IRQ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire vic_pkg::vic_bus_s bus,
  output logic [vic_pkg::DATA_W-1:0] rdData,
  input wire logic [IRQ_COUNT-1:0] irqLines,
  input wire logic [vic_pkg::NUM_TRAP-1:0] trapIn,
  input wire vic_pkg::vic_core_s core,
  output var vic_pkg::vic_req_s coreReq,
  output logic [vic_pkg::LVL_W-1:0] cpuLevel
);
  import vic_pkg::*;

  // ----------------------------------------------------------------
  // Sizes and state
  // ----------------------------------------------------------------
  localparam int FW = (IRQ_COUNT + WORD_BITS - 1) / WORD_BITS;
  localparam int PW = (IRQ_COUNT + PRIO_SLOTS - 1) / PRIO_SLOTS;
  localparam logic [IRQ_COUNT-1:0] RESV = IRQ_RESERVED[IRQ_COUNT-1:0];

  if (IRQ_COUNT < 1 || IRQ_COUNT > NUM_IRQ) begin : g_bad_count
    $error("Source count exceeds the vector table.");
  end

  typedef struct packed {
    logic [IRQ_COUNT-1:0] syncA;
    logic [IRQ_COUNT-1:0] syncB;
    logic [IRQ_COUNT-1:0] flags;
    logic [IRQ_COUNT-1:0] enables;
    logic [IRQ_COUNT-1:0][PRIO_W-1:0] prio;
    logic [NUM_TRAP-1:0] trapFlags;
    logic altSel;
    logic [LVL_W-1:0] cpuLvl;
    logic [VEC_W-1:0] pendVec;
    logic [LVL_W-1:0] pendLvl;
    logic [DATA_W-1:0] rdData;
    logic req;
    logic [VEC_W-1:0] reqNum;
    logic [PC_W-1:0] reqAddr;
    logic [LVL_W-1:0] reqLvl;
  } vic_state_s;

  vic_state_s st_r;
  vic_state_s st_nxt;
  logic [IRQ_COUNT-1:0] userElig;
  logic userValid;
  logic [VEC_W-1:0] userIdx;
  logic [PRIO_W-1:0] userLvl;
  logic trapValid;
  logic [VEC_W-1:0] trapIdx;
  logic [FW*WORD_BITS-1:0] flagPad;
  logic [FW*WORD_BITS-1:0] enPad;
  logic [PW*PRIO_SLOTS-1:0][PRIO_W-1:0] prioPad;
  logic [VEC_W-1:0] winNum;
  logic [LVL_W-1:0] winLvl;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  for (genvar i = 0; i < IRQ_COUNT; i++) begin : g_elig
    assign userElig[i] = st_r.flags[i] & st_r.enables[i] &
      ({1'b0, st_r.prio[i]} > st_r.cpuLvl);
  end

  vic_arbiter #(.N(IRQ_COUNT)) u_user_arb (
    .eligible(userElig),
    .prio(st_r.prio),
    .valid(userValid),
    .idx(userIdx),
    .level(userLvl)
  );

  vic_arbiter #(.N(NUM_TRAP)) u_trap_arb (
    .eligible(st_r.trapFlags & {NUM_TRAP{TRAP_LEVEL > st_r.cpuLvl}}),
    .prio('0),
    .valid(trapValid),
    .idx(trapIdx),
    .level()
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    flagPad = '0;
    flagPad[IRQ_COUNT-1:0] = st_r.flags;
    enPad = '0;
    enPad[IRQ_COUNT-1:0] = st_r.enables;
    prioPad = '0;
    prioPad[IRQ_COUNT-1:0] = st_r.prio;
    winNum = '0;
    winLvl = '0;
    if (trapValid) begin
      winNum = trapIdx;
      winLvl = TRAP_LEVEL;
    end else if (userValid) begin
      winNum = IRQ_VEC_OFFSET + userIdx;
      winLvl = {1'b0, userLvl};
    end
    if (ce) begin
      st_nxt.syncA = irqLines & ~RESV;
      st_nxt.syncB = st_r.syncA;
      st_nxt.rdData = REG_RESET;
      if (bus.wr) begin
        for (int w = 0; w < FW; w++) begin
          if (bus.addr == OFS_FLAG_BASE + ADDR_W'(w)) begin
            flagPad[w*WORD_BITS +: WORD_BITS] &= bus.wdata;
          end
          if (bus.addr == OFS_ENABLE_BASE + ADDR_W'(w)) begin
            enPad[w*WORD_BITS +: WORD_BITS] = bus.wdata;
          end
        end
        for (int w = 0; w < PW; w++) begin
          if (bus.addr == OFS_PRIO_BASE + ADDR_W'(w)) begin
            for (int s = 0; s < PRIO_SLOTS; s++) begin
              prioPad[w*PRIO_SLOTS+s] = bus.wdata[s*PRIO_SLOT_W +: PRIO_W];
            end
          end
        end
        if (bus.addr == OFS_CONTROL) begin
          st_nxt.altSel = bus.wdata[ALT_SEL_BIT];
        end
        if (bus.addr == OFS_CPU_LEVEL) begin
          st_nxt.cpuLvl[CPU_TOP_BIT-1:0] = bus.wdata[CPU_TOP_BIT-1:0];
        end
        if (bus.addr == OFS_TRAP_FLAGS) begin
          st_nxt.trapFlags = st_r.trapFlags & bus.wdata[NUM_TRAP-1:0];
        end
      end
      // Hardware set wins over a software clear in the same cycle.
      st_nxt.flags = flagPad[IRQ_COUNT-1:0] | st_r.syncB;
      st_nxt.enables = enPad[IRQ_COUNT-1:0];
      st_nxt.prio = prioPad[IRQ_COUNT-1:0];
      st_nxt.trapFlags = st_nxt.trapFlags | (trapIn & TRAP_IMPL);
      if (bus.rd) begin
        for (int w = 0; w < FW; w++) begin
          if (bus.addr == OFS_FLAG_BASE + ADDR_W'(w)) begin
            st_nxt.rdData = flagPad[w*WORD_BITS +: WORD_BITS];
          end
          if (bus.addr == OFS_ENABLE_BASE + ADDR_W'(w)) begin
            st_nxt.rdData = enPad[w*WORD_BITS +: WORD_BITS];
          end
        end
        for (int w = 0; w < PW; w++) begin
          if (bus.addr == OFS_PRIO_BASE + ADDR_W'(w)) begin
            for (int s = 0; s < PRIO_SLOTS; s++) begin
              st_nxt.rdData[s*PRIO_SLOT_W +: PRIO_SLOT_W] = {1'b0, prioPad[w*PRIO_SLOTS+s]};
            end
          end
        end
        case (bus.addr)
          OFS_CONTROL: begin
            st_nxt.rdData[ALT_SEL_BIT] = st_r.altSel;
          end
          OFS_CPU_LEVEL: begin
            st_nxt.rdData[LVL_W-1:0] = st_r.cpuLvl;
          end
          OFS_TRAP_FLAGS: begin
            st_nxt.rdData[NUM_TRAP-1:0] = st_r.trapFlags;
          end
          OFS_PENDING: begin
            st_nxt.rdData[VEC_W-1:0] = st_r.pendVec;
            st_nxt.rdData[PEND_LVL_LSB +: LVL_W] = st_r.pendLvl;
          end
          default: begin
          end
        endcase
      end
      if (core.ret) begin
        st_nxt.cpuLvl = core.retLevel;
      end
      if (core.ack && st_r.req) begin
        st_nxt.pendVec = st_r.reqNum;
        st_nxt.pendLvl = st_r.reqLvl;
        st_nxt.cpuLvl = st_r.reqLvl;
      end
      st_nxt.req = trapValid | userValid;
      st_nxt.reqNum = winNum;
      st_nxt.reqLvl = winLvl;
      st_nxt.reqAddr = (st_r.altSel ? ALT_BASE : PRIMARY_BASE) +
        PC_W'({winNum, 1'b0});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
  assign coreReq = '{req: st_r.req, num: st_r.reqNum, addr: st_r.reqAddr, level: st_r.reqLvl};
  assign cpuLevel = st_r.cpuLvl;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  fixed_latency_a: assert property (@(posedge clk) disable iff (rst)
    ce && (trapValid || userValid) |=> st_r.req)
    else $error("Winner was not presented one cycle later.");

  above_level_a: assert property (@(posedge clk) disable iff (rst)
    ce && st_r.req |=> !$past(st_r.req) || $past(st_r.reqLvl) > $past(st_r.cpuLvl, 2)
      || $past(core.ret) || $past(core.ack) || $past(bus.wr))
    else $error("Request level does not exceed the core level.");

  trap_first_a: assert property (@(posedge clk) disable iff (rst)
    ce && trapValid |=> st_r.reqNum < IRQ_VEC_OFFSET && st_r.reqLvl == 4'h8)
    else $error("User source beat a pending trap.");

  irq_zero_map_a: assert property (@(posedge clk) disable iff (rst)
    ce && !trapValid && userValid && userIdx == 7'h00 |=> st_r.reqNum == 7'h08 &&
      st_r.reqAddr == ($past(st_r.altSel) ? 24'h000114 : 24'h000014))
    else $error("External irq zero took a wrong vector.");

  dma_zero_map_a: assert property (@(posedge clk) disable iff (rst)
    ce && !trapValid && userValid && userIdx == 7'h04 |=> st_r.reqNum == 7'h0c &&
      st_r.reqAddr == ($past(st_r.altSel) ? 24'h00011c : 24'h00001c))
    else $error("First DMA completion took a wrong vector.");

  tie_order_a: assert property (@(posedge clk) disable iff (rst)
    ce && !trapValid && userElig[1] && userElig[4] && st_r.prio[1] == st_r.prio[4]
      |=> st_r.reqNum != 7'h0c)
    else $error("Equal levels were not resolved by index.");

  flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
    !(bus.wr && bus.addr >= OFS_FLAG_BASE && bus.addr < OFS_ENABLE_BASE)
      |=> (st_r.flags & $past(st_r.flags)) == $past(st_r.flags))
    else $error("A request flag dropped without a software write.");

  reserved_quiet_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (st_r.flags & RESV) == '0)
    else $error("A reserved request number raised a flag.");

  level_top_a: assert property (@(posedge clk) disable iff (rst)
    ce && bus.wr && bus.addr == OFS_CPU_LEVEL && !core.ret && !core.ack
      |=> st_r.cpuLvl[3] == $past(st_r.cpuLvl[3]))
    else $error("Software changed the top level bit.");

  ack_latch_a: assert property (@(posedge clk) disable iff (rst)
    ce && core.ack && st_r.req |=> st_r.pendVec == $past(st_r.reqNum) &&
      st_r.pendLvl == $past(st_r.reqLvl) && st_r.cpuLvl == $past(st_r.reqLvl))
    else $error("Taken vector or level was not latched.");

  reset_clear_a: assert property (@(posedge clk)
    rst |=> !st_r.req && st_r.cpuLvl == 4'h0 && !st_r.altSel)
    else $error("Reset left state behind.");

endmodule // vic_controller
`default_nettype wire

// File: verilog/vic_pkg.sv
// Constants and carrier types of the vectored interrupt controller.
`default_nettype none
package vic_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 118;
  localparam int NUM_TRAP = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int VEC_W = 7;
  localparam int LVL_W = 4;
  localparam int PRIO_W = 3;
  localparam int PC_W = 24;
  localparam int WORD_BITS = 16;
  localparam int PRIO_SLOTS = 4;
  localparam int PRIO_SLOT_W = 4;

  // ----------------------------------------------------------------
  // Vector tables
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PRIMARY_BASE = 24'h000004;
  localparam logic [PC_W-1:0] ALT_BASE = 24'h000104;
  localparam logic [VEC_W-1:0] IRQ_VEC_OFFSET = 7'h08;
  localparam logic [LVL_W-1:0] TRAP_LEVEL = 4'h8;
  localparam logic [NUM_TRAP-1:0] TRAP_IMPL = 8'h3e;
  localparam logic [NUM_IRQ-1:0] IRQ_RESERVED = (118'h1 << 15) | (118'h1 << 18) |
    (118'h1 << 45) | (118'h1 << 62) | (118'h1 << 67) | ({NUM_IRQ{1'b1}} << 72);

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CPU_LEVEL = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_TRAP_FLAGS = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_FLAG_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 8'h40;
  localparam int ALT_SEL_BIT = 15;
  localparam int CPU_TOP_BIT = 3;
  localparam int PEND_LVL_LSB = 8;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } vic_bus_s;

  typedef struct packed {
    logic req;
    logic [VEC_W-1:0] num;
    logic [PC_W-1:0] addr;
    logic [LVL_W-1:0] level;
  } vic_req_s;

  typedef struct packed {
    logic ack;
    logic ret;
    logic [LVL_W-1:0] retLevel;
  } vic_core_s;

endpackage
`default_nettype wire
